// File: core/icm_pkg.sv
package icm_pkg;
  localparam int MODE_W = 3;
  localparam int TIMER_W = 32;
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_EVERY_EDGE = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_RISE4 = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;
  localparam logic [2:0] MODE_FIRST_EDGE = 3'h6;
  localparam logic [2:0] MODE_IRQ_ONLY = 3'h7;
  localparam int PRESCALE_W = 4;
  localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam int PRIO_W = 3;
  localparam int SUBPRIO_W = 2;
endpackage

// File: core/icm_edge_detect.sv
`timescale 1ns/1ps
module icm_edge_detect
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sig_in,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic prev;
    logic valid;
  } icm_edge_state_type;
  icm_edge_state_type state;
  icm_edge_state_type next_state;
  always_comb
  begin
    next_state.prev = sig_in;
    next_state.valid = 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end
  // No edge reported before first sample after reset
  assign rise = state.valid & sig_in & ~state.prev;
  assign fall = state.valid & ~sig_in & state.prev;
endmodule // icm_edge_detect

// File: core/icm_capture.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Mode 000 disables channel, no events.
// - Mode 001 captures every edge.
// - Mode 010 captures falling edges only.
// - Mode 011 captures rising edges only.
// - Mode 100 captures every fourth rising edge.
// - Mode 101 captures every sixteenth rising edge.
// - Mode 110: chosen first edge, then every edge.
// - Mode 111 interrupts only while core sleeps.
// - Separate capture and error flags, shared priority.
module icm_capture
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [icm_pkg::MODE_W-1:0] capture_mode_select,
  input wire logic first_edge_rising,
  input wire logic core_sleep_idle,
  input wire logic [icm_pkg::TIMER_W-1:0] timer_count,
  input wire logic capture_in,
  input wire logic buffer_read,
  input wire logic capture_irq_clear,
  input wire logic capture_error_irq_clear,
  input wire logic [icm_pkg::PRIO_W-1:0] irq_priority,
  input wire logic [icm_pkg::SUBPRIO_W-1:0] irq_subpriority,
  output logic [icm_pkg::TIMER_W-1:0] capture_buffer,
  output logic capture_buffer_full,
  output logic capture_irq,
  output logic capture_error_irq,
  output logic [icm_pkg::PRIO_W-1:0] irq_priority_out,
  output logic [icm_pkg::SUBPRIO_W-1:0] irq_subpriority_out
);
  import icm_pkg::*;
  typedef struct packed {
    logic [TIMER_W-1:0] buffer;
    logic full;
    logic cap_flag;
    logic err_flag;
    logic [PRESCALE_W-1:0] prescale;
    logic armed;
    logic [MODE_W-1:0] last_mode;
    logic [PRIO_W-1:0] prio;
    logic [SUBPRIO_W-1:0] subprio;
  } icm_state_type;
  icm_state_type state;
  icm_state_type next_state;
  logic rise;
  logic fall;
  logic event_hit;
  logic irq_hit;
  icm_edge_detect u_edge
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sig_in(capture_in),
    .rise(rise),
    .fall(fall)
  );
  always_comb
  begin
    next_state = state;
    event_hit = 1'b0;
    irq_hit = 1'b0;
    next_state.last_mode = capture_mode_select;
    // Priority copies lag the inputs by one cycle
    next_state.prio = irq_priority;
    next_state.subprio = irq_subpriority;
    // Mode change restarts prescaler and first-edge wait
    if (capture_mode_select != state.last_mode)
    begin
      next_state.prescale = PRESCALE_RESET;
      next_state.armed = 1'b0;
    end
    else
    begin
      case (capture_mode_select)
        MODE_OFF: event_hit = 1'b0;
        MODE_EVERY_EDGE: event_hit = rise | fall;
        MODE_FALL: event_hit = fall;
        MODE_RISE: event_hit = rise;
        MODE_RISE4:
        begin
          if (rise)
          begin
            event_hit = (state.prescale == PRESCALE_4_LAST);
            next_state.prescale = event_hit ? PRESCALE_RESET : state.prescale + 4'h1;
          end
        end
        MODE_RISE16:
        begin
          if (rise)
          begin
            event_hit = (state.prescale == PRESCALE_16_LAST);
            next_state.prescale = state.prescale + 4'h1;
          end
        end
        MODE_FIRST_EDGE:
        begin
          if (state.armed)
            event_hit = rise | fall;
          else if (first_edge_rising ? rise : fall)
          begin
            event_hit = 1'b1;
            next_state.armed = 1'b1;
          end
        end
        MODE_IRQ_ONLY: irq_hit = core_sleep_idle & (rise | fall);
        default: event_hit = 1'b0;
      endcase
    end
    // One-word buffer: unread word plus new event is an overrun error
    if (buffer_read)
      next_state.full = 1'b0;
    if (capture_irq_clear)
      next_state.cap_flag = 1'b0;
    if (capture_error_irq_clear)
      next_state.err_flag = 1'b0;
    // Sets follow clears, so a same-cycle set wins
    if (event_hit)
    begin
      if (state.full && !buffer_read)
        next_state.err_flag = 1'b1;
      else
      begin
        next_state.buffer = timer_count;
        next_state.full = 1'b1;
      end
      next_state.cap_flag = 1'b1;
    end
    if (irq_hit)
      next_state.cap_flag = 1'b1;
  end
  // Synchronous reset clears every flag and the prescaler
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end
  assign capture_buffer = state.buffer;
  assign capture_buffer_full = state.full;
  assign capture_irq = state.cap_flag;
  assign capture_error_irq = state.err_flag;
  assign irq_priority_out = state.prio;
  assign irq_subpriority_out = state.subprio;

  AST_OFF_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_OFF && !capture_irq) ##1 (capture_mode_select == MODE_OFF) |-> !capture_irq)
    else $error("Capture flag raised while disabled");
  AST_EDGE_ALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_EVERY_EDGE && $stable(capture_mode_select) && (rise || fall)) |=> capture_irq)
    else $error("Edge mode missed an edge");
  AST_FALL_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_FALL && $stable(capture_mode_select) && fall) |=> capture_irq)
    else $error("Falling edge not captured");
  AST_RISE_IGNORE_FALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_RISE && fall && !capture_irq && !buffer_read) |=> !capture_buffer_full || $past(capture_buffer_full))
    else $error("Falling edge captured in rise mode");
  AST_PRESCALE4: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_RISE4 && $stable(capture_mode_select) && rise && state.prescale != PRESCALE_4_LAST)
      |-> !event_hit)
    else $error("Prescale by four fired early");
  AST_PRESCALE16: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_RISE16 && $stable(capture_mode_select) && rise && state.prescale == PRESCALE_16_LAST)
      |=> capture_irq && state.prescale == PRESCALE_RESET)
    else $error("Prescale by sixteen missed");
  AST_FIRST_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_FIRST_EDGE && $stable(capture_mode_select) && !state.armed
      && (first_edge_rising ? fall : rise)) |-> !event_hit)
    else $error("Wrong first edge captured");
  AST_IRQ_ONLY_AWAKE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_IRQ_ONLY) |-> !event_hit && (irq_hit == (core_sleep_idle && (rise || fall)
      && $stable(capture_mode_select))))
    else $error("Interrupt-only mode misbehaved");
  AST_STORE_TIMER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (event_hit && !capture_buffer_full) |=> capture_buffer == $past(timer_count) && capture_buffer_full)
    else $error("Timer value not stored on event");
  AST_OVERRUN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (event_hit && capture_buffer_full && !buffer_read) |=> capture_error_irq && $stable(capture_buffer))
    else $error("Overrun not flagged");

  // Checks on the decoded event, the sticky flags and the restart
  AST_OFF_NO_EVENT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_OFF) |-> !event_hit && !irq_hit)
    else $error("Event decoded while disabled");
  AST_FALL_IGNORE_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_FALL && rise) |-> !event_hit)
    else $error("Rising edge captured in fall mode");
  AST_RISE_TAKEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_RISE && $stable(capture_mode_select) && rise) |=> capture_irq)
    else $error("Rising edge not captured");
  AST_PRESCALE4_FIRE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_RISE4 && $stable(capture_mode_select) && rise && state.prescale == PRESCALE_4_LAST)
      |=> capture_irq && state.prescale == PRESCALE_RESET)
    else $error("Prescale by four missed");
  AST_PRESCALE16_EARLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_RISE16 && rise && state.prescale != PRESCALE_16_LAST) |-> !event_hit)
    else $error("Prescale by sixteen fired early");
  AST_FIRST_EDGE_TAKEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_FIRST_EDGE && $stable(capture_mode_select) && !state.armed
      && (first_edge_rising ? rise : fall)) |=> capture_irq && state.armed)
    else $error("Chosen first edge not captured");
  AST_IRQ_ONLY_NO_BUFFER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_mode_select == MODE_IRQ_ONLY && !buffer_read)
      |=> $stable(capture_buffer_full) && $stable(capture_buffer))
    else $error("Interrupt-only mode wrote the buffer");
  AST_ERR_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_error_irq && !capture_error_irq_clear) |=> capture_error_irq)
    else $error("Error flag dropped without a clear");
  AST_CAP_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capture_irq && !capture_irq_clear) |=> capture_irq)
    else $error("Capture flag dropped without a clear");
  AST_PRIO_COPY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> irq_priority_out == $past(irq_priority) && irq_subpriority_out == $past(irq_subpriority))
    else $error("Shared priority not passed on");
  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (event_hit && capture_irq_clear) |=> capture_irq)
    else $error("Clear beat a capture event");
  AST_OVERRUN_KEEPS_CAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (event_hit && capture_buffer_full && !buffer_read) |=> capture_irq && capture_buffer_full)
    else $error("Overrun lost the capture flag");
  AST_MODE_RESTART: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$stable(capture_mode_select) |=> state.prescale == PRESCALE_RESET && !state.armed)
    else $error("Mode change left prescaler or arming");
endmodule // icm_capture

// File: test/icm_sig_model.sv
`timescale 1ns/1ps
// Far-side input line; moves on the falling edge so the sampling edge never races it
module icm_sig_model
(
  input wire logic sys_clk,
  input wire logic lvl,
  output logic sig
);
  logic held = 1'b0;
  initial sig = 1'b0;
  // Level taken on the rising edge so a bench change at the falling edge never races the line
  always @(posedge sys_clk)
    held <= lvl;
  always @(negedge sys_clk)
    sig <= held;
endmodule // icm_sig_model

// File: test/tb_input_capture_mode_logic.sv
`timescale 1ns/1ps
module tb_input_capture_mode_logic;
  import icm_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, lvl = 1'b0, fer = 1'b0, slp = 1'b0;
  logic rd = 1'b0, clr = 1'b0, eclr = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [31:0] tmr = 32'h0;
  logic [2:0] pri = 3'h5;
  logic [1:0] sub = 2'h2;
  logic sig, full, irq, eirq, s;
  logic [31:0] buf_q;
  logic [2:0] pri_o;
  logic [1:0] sub_o;
  int n_errors = 0;
  int checks_done = 0;
  icm_sig_model src (.sys_clk(sys_clk), .lvl(lvl), .sig(sig));
  icm_capture uut (.sys_clk(sys_clk), .rst_n(rst_n), .capture_mode_select(mode), .first_edge_rising(fer),
    .core_sleep_idle(slp), .timer_count(tmr), .capture_in(sig), .buffer_read(rd), .capture_irq_clear(clr),
    .capture_error_irq_clear(eclr), .irq_priority(pri), .irq_subpriority(sub), .capture_buffer(buf_q),
    .capture_buffer_full(full), .capture_irq(irq), .capture_error_irq(eirq), .irq_priority_out(pri_o),
    .irq_subpriority_out(sub_o));
  initial forever #5 sys_clk = ~sys_clk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Mode change cycle drops edges, so settle before driving
  task set_mode(input logic [2:0] m);
    @(negedge sys_clk);
    mode = m;
    repeat (3) @(negedge sys_clk);
  endtask
  task hit(input logic l, output logic seen);
    @(negedge sys_clk);
    lvl = l;
    repeat (4) @(negedge sys_clk);
    seen = irq;
    clr = 1'b1;
    rd = 1'b1;
    @(negedge sys_clk);
    clr = 1'b0;
    rd = 1'b0;
  endtask
  task t_basic;
    set_mode(MODE_OFF);
    check(pri_o, 3'h5);
    hit(1'b1, s); check(s, 0);
    hit(1'b0, s); check(s, 0);
    set_mode(MODE_EVERY_EDGE);
    tmr = 32'h1234ABCD;
    hit(1'b1, s); check(s, 1);
    check(buf_q, 32'h1234ABCD);
    hit(1'b0, s); check(s, 1);
    set_mode(MODE_FALL);
    hit(1'b1, s); check(s, 0);
    hit(1'b0, s); check(s, 1);
    set_mode(MODE_RISE);
    hit(1'b1, s); check(s, 1);
    hit(1'b0, s); check(s, 0);
  endtask
  task t_prescale;
    set_mode(MODE_RISE4);
    for (int i = 1; i <= 8; i++)
    begin
      hit(1'b1, s); check(s, i % 4 == 0);
      hit(1'b0, s);
    end
    set_mode(MODE_RISE16);
    for (int i = 1; i <= 32; i++)
    begin
      hit(1'b1, s); check(s, i % 16 == 0);
      hit(1'b0, s);
    end
  endtask
  task t_first;
    fer = 1'b1;
    set_mode(MODE_OFF);
    hit(1'b1, s);
    set_mode(MODE_FIRST_EDGE);
    hit(1'b0, s); check(s, 0);
    hit(1'b1, s); check(s, 1);
    hit(1'b0, s); check(s, 1);
    fer = 1'b0;
    set_mode(MODE_OFF);
    set_mode(MODE_FIRST_EDGE);
    hit(1'b1, s); check(s, 0);
    hit(1'b0, s); check(s, 1);
    hit(1'b1, s); check(s, 1);
    hit(1'b0, s); check(s, 1);
  endtask
  task t_irq_only;
    set_mode(MODE_IRQ_ONLY);
    pri = 3'h6;
    sub = 2'h1;
    hit(1'b1, s); check(s, 0);
    slp = 1'b1;
    hit(1'b0, s); check(s, 1);
    check(full, 0);
    check(pri_o, 3'h6);
    check(sub_o, 2'h1);
    slp = 1'b0;
  endtask
  // Two events with no read in between overrun the buffer
  // Second event meets both clears in one cycle, so the sets must win
  task t_overrun;
    set_mode(MODE_EVERY_EDGE);
    tmr = 32'h0000A5A5;
    lvl = 1'b1;
    repeat (4) @(negedge sys_clk);
    tmr = 32'h00005A5A;
    lvl = 1'b0;
    @(negedge sys_clk);
    clr = 1'b1;
    eclr = 1'b1;
    @(negedge sys_clk);
    clr = 1'b0;
    eclr = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(eirq, 1);
    check(irq, 1);
    check(full, 1);
    check(buf_q, 32'h0000A5A5);
    eclr = 1'b1;
    @(negedge sys_clk);
    eclr = 1'b0;
    @(negedge sys_clk);
    check(eirq, 0);
    check(irq, 1);
  endtask
  initial
  begin
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    t_basic;
    t_prescale;
    t_first;
    t_irq_only;
    t_overrun;
    results;
  end
  // About 660 cycles of work; generous margin
  initial
  begin
    #200000;
    n_errors++;
    results;
  end
endmodule // tb_input_capture_mode_logic
